// ### include/idca_pkg.sv
// Purpose: Shared constants and carriers for the D-channel access logic
// Assumes: One D bit and one echo bit per frame bit slot, marked by strobes
// Notes: Counts are in echo bits, not clock cycles
package idca_pkg;
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    localparam logic [CNT_W-1:0] NEED_C1_NORMAL = 4'h8;
    localparam logic [CNT_W-1:0] NEED_C2_NORMAL = 4'ha;
    localparam logic [CNT_W-1:0] NEED_C1_LOWER = 4'h9;
    localparam logic [CNT_W-1:0] NEED_C2_LOWER = 4'hb;
    localparam logic D_IDLE = 1'b1;

    typedef enum logic [1:0] {
        ST_WAIT,
        ST_SEND
    } idca_state_e;

    // One slot from the framer: strobes and bit values
    typedef struct packed {
        logic d_slot;
        logic echo_slot;
        logic echo_bit;
    } idca_line_s;

    // Layer 2 side request
    typedef struct packed {
        logic pending;
        logic class2;
        logic data_bit;
        logic last;
    } idca_req_s;
endpackage : idca_pkg

// ### rtl/idca_sync.sv
// Purpose: Two-stage synchroniser for line-side level inputs
// Assumes: Inputs come from outside the clk_i domain
// Notes: First stage is read only by the second stage
module idca_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk_i, // System clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic [W-1:0] d_i, // Asynchronous inputs
    output logic [W-1:0] q_o // Synchronised outputs
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule : idca_sync

// ### rtl/idca_access.sv
// Purpose: Terminal D-channel contention: echo compare, abort and priority wait
// Assumes: Framer gives slot strobes from recovered bit timing, as line inputs
// Notes: Strobes are edge-detected after synchronising, one event per slot
// How it works
// - Each sent bit compared with its echo; any mismatch aborts at once.
// - First D bit after a mismatch is idle ONE.
// - Compare and abort apply in every class and level.
// - After errored echo, level kept; at normal level need 8 (class 1) or 10 (class 2) ONEs.
// - After good frame, wait 9 (class 1) or 11 (class 2) ONEs.
// - Good frame and nothing pending: back to normal after 9 or 11 ONEs.
module idca_access (
    input wire logic clk_i, // 20 MHz clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic d_slot_i, // D bit slot strobe from framer (line)
    input wire logic echo_slot_i, // Echo bit slot strobe from framer (line)
    input wire logic echo_bit_i, // Received echo bit value (line)
    input wire logic req_pending_i, // Layer 2 has a frame to send
    input wire logic req_class2_i, // Pending frame is priority class 2
    input wire logic req_bit_i, // Next frame bit to send
    input wire logic req_last_i, // Current bit is the frame's last
    output logic d_bit_o, // D bit to transmit this slot
    output logic bit_take_o, // Pulse: req_bit_i consumed
    output logic frame_done_o, // Pulse: frame sent with clean echo
    output logic frame_abort_o, // Pulse: frame aborted on mismatch
    output logic lower_level_o // Priority level is lower
);
    idca_pkg::idca_line_s line_raw;
    idca_pkg::idca_line_s line_s;
    idca_pkg::idca_req_s req;

    // Line levels grouped before the synchroniser so all three see equal delay
    assign line_raw = '{
        d_slot: d_slot_i,
        echo_slot: echo_slot_i,
        echo_bit: echo_bit_i
    };

    // Request comes from layer 2 logic on this clock; no sync needed
    assign req = '{
        pending: req_pending_i,
        class2: req_class2_i,
        data_bit: req_bit_i,
        last: req_last_i
    };

    idca_sync #(
        .W($bits(idca_pkg::idca_line_s))
    ) u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .d_i(line_raw),
        .q_o(line_s)
    );

    // Whole state of the block, registered as one word
    typedef struct packed {
        idca_pkg::idca_state_e state;
        logic [idca_pkg::CNT_W-1:0] ones;
        logic lower;
        logic d_slot_q;
        logic echo_slot_q;
        logic sent_bit;
        logic sent_last;
        logic await_echo;
        logic d_bit;
        logic take;
        logic done;
        logic abort;
    } idca_regs_s;

    idca_regs_s cur_ff;
    idca_regs_s nxt_cur;

    // Echo ONEs needed before sending, per class and level
    function automatic logic [idca_pkg::CNT_W-1:0] need_ones(input logic class2,
                                                             input logic lower);
        if (lower) begin
            need_ones = class2 ? idca_pkg::NEED_C2_LOWER : idca_pkg::NEED_C1_LOWER;
        end else begin
            need_ones = class2 ? idca_pkg::NEED_C2_NORMAL : idca_pkg::NEED_C1_NORMAL;
        end
    endfunction : need_ones

    // Counter holds at its top value; a long idle line must not wrap to zero
    function automatic logic [idca_pkg::CNT_W-1:0] sat_inc(
        input logic [idca_pkg::CNT_W-1:0] cnt
    );
        if (cnt == {idca_pkg::CNT_W{1'b1}}) begin
            sat_inc = cnt;
        end else begin
            sat_inc = cnt + {{(idca_pkg::CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction : sat_inc

    // Loads one frame bit; used for the first bit and every later one
    function automatic idca_regs_s load_bit(input idca_regs_s cur,
                                           input idca_pkg::idca_req_s rq);
        load_bit = cur;
        load_bit.d_bit = rq.data_bit;
        load_bit.sent_bit = rq.data_bit;
        load_bit.sent_last = rq.last;
        load_bit.await_echo = 1'b1;
        load_bit.take = 1'b1;
    endfunction : load_bit

    // Leaves a frame: line back to idle ONE and the ONE count restarts
    function automatic idca_regs_s to_wait(input idca_regs_s cur);
        to_wait = cur;
        to_wait.d_bit = idca_pkg::D_IDLE;
        to_wait.state = idca_pkg::ST_WAIT;
        to_wait.ones = idca_pkg::CNT_RST;
    endfunction : to_wait

    // Rising edge of a synchronised strobe against its registered copy
    function automatic logic slot_rise(input logic now, input logic was);
        slot_rise = now & ~was;
    endfunction : slot_rise

    // A strobe counts once per rising edge, however long it stands
    logic d_evt;
    logic e_evt;
    assign d_evt = slot_rise(line_s.d_slot, cur_ff.d_slot_q);
    assign e_evt = slot_rise(line_s.echo_slot, cur_ff.echo_slot_q);

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.d_slot_q = line_s.d_slot;
        nxt_cur.echo_slot_q = line_s.echo_slot;
        nxt_cur.take = 1'b0;
        nxt_cur.done = 1'b0;
        nxt_cur.abort = 1'b0;

        if (e_evt) begin
            if (!line_s.echo_bit) begin
                nxt_cur.ones = idca_pkg::CNT_RST;
            end else begin
                nxt_cur.ones = sat_inc(cur_ff.ones);
            end
        end

        unique case (cur_ff.state)
            idca_pkg::ST_WAIT: begin
                if (cur_ff.lower && !req.pending &&
                    cur_ff.ones >= need_ones(1'b0, 1'b1) && !req.class2) begin
                    nxt_cur.lower = 1'b0;
                end else if (cur_ff.lower && !req.pending &&
                             cur_ff.ones >= need_ones(1'b1, 1'b1)) begin
                    nxt_cur.lower = 1'b0;
                end
                if (d_evt) begin
                    nxt_cur.d_bit = idca_pkg::D_IDLE;
                    if (req.pending && cur_ff.ones >= need_ones(req.class2, cur_ff.lower)) begin
                        nxt_cur = load_bit(nxt_cur, req);
                        nxt_cur.state = idca_pkg::ST_SEND;
                    end
                end
            end
            idca_pkg::ST_SEND: begin
                // compare echo in every class and level
                if (e_evt && cur_ff.await_echo) begin
                    nxt_cur.await_echo = 1'b0;
                    if (line_s.echo_bit != cur_ff.sent_bit) begin
                        nxt_cur = to_wait(nxt_cur);
                        nxt_cur.abort = 1'b1;
                    end else if (cur_ff.sent_last) begin
                        nxt_cur = to_wait(nxt_cur);
                        nxt_cur.lower = 1'b1;
                        nxt_cur.done = 1'b1;
                    end
                end else if (d_evt && !cur_ff.await_echo) begin
                    // Echo of previous bit checked; send next
                    nxt_cur = load_bit(nxt_cur, req);
                end
            end
            // Unused state code: recover to waiting
            default: begin
                nxt_cur.state = idca_pkg::ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Idle ONE from reset; strobe copies low to match pins at rest
            cur_ff <= '{
                state: idca_pkg::ST_WAIT,
                ones: idca_pkg::CNT_RST,
                lower: 1'b0,
                d_slot_q: 1'b0,
                echo_slot_q: 1'b0,
                sent_bit: idca_pkg::D_IDLE,
                sent_last: 1'b0,
                await_echo: 1'b0,
                d_bit: idca_pkg::D_IDLE,
                take: 1'b0,
                done: 1'b0,
                abort: 1'b0
            };
        end else begin
            cur_ff <= nxt_cur;
        end
    end


    // Outputs are register fields; nothing sits after the flops
    assign d_bit_o = cur_ff.d_bit;
    assign bit_take_o = cur_ff.take;
    assign frame_done_o = cur_ff.done;
    assign frame_abort_o = cur_ff.abort;
    assign lower_level_o = cur_ff.lower;
endmodule : idca_access

// ### verification/idca_access_chk.sv
// Purpose: Port checker for the D-channel access block
// Assumes: Echo strobe and bit pass two sync stages, as in the block
// Notes: Echo ONE count here restarts on frame end, like the block's
module idca_access_chk (
    input wire logic clk_i, reset_n_i, d_slot_i, echo_slot_i, echo_bit_i,
    input wire logic req_pending_i, req_class2_i, req_bit_i, req_last_i,
    input wire logic d_bit_o, bit_take_o, frame_done_o, frame_abort_o, lower_level_o
);
    logic [2:0] s_ff;
    logic [1:0] b_ff;
    logic in_ff;
    logic [3:0] ones_ff;
    wire rise = s_ff[1] & ~s_ff[2];
    wire [3:0] need_n = req_class2_i ? idca_pkg::NEED_C2_NORMAL : idca_pkg::NEED_C1_NORMAL;
    wire [3:0] need_l = req_class2_i ? idca_pkg::NEED_C2_LOWER : idca_pkg::NEED_C1_LOWER;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_ff <= 3'h0;
            b_ff <= 2'h0;
            in_ff <= 1'b0;
            ones_ff <= 4'h0;
        end else begin
            s_ff <= {s_ff[1:0], echo_slot_i};
            b_ff <= {b_ff[0], echo_bit_i};
            in_ff <= (in_ff | bit_take_o) & ~(frame_done_o | frame_abort_o);
            if (frame_done_o | frame_abort_o)
                ones_ff <= 4'h0;
            else if (rise)
                ones_ff <= !b_ff[1] ? 4'h0 : (ones_ff == 4'hf) ? 4'hf : ones_ff + 4'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_mismatch_abort: assert property (rise && in_ff && (b_ff[1] != d_bit_o) |->
        ##[1:2] frame_abort_o) else $error("echo mismatch not aborted");
    a_abort_idle: assert property (frame_abort_o |-> (d_bit_o && !bit_take_o)[*8])
        else $error("no idle ONE after abort");
    a_abort_cause: assert property (frame_abort_o |-> in_ff && !frame_done_o)
        else $error("abort outside a frame");
    a_start_normal: assert property (bit_take_o && !in_ff && !lower_level_o |->
        ones_ff >= need_n) else $error("early start at normal level");
    a_start_lower: assert property (bit_take_o && !in_ff && lower_level_o |->
        ones_ff >= need_l) else $error("early start at lower level");
    a_done_lower: assert property (frame_done_o |-> ##[0:1] lower_level_o)
        else $error("level not lowered after frame");
    a_level_return: assert property (lower_level_o && !req_pending_i && !in_ff &&
        ones_ff >= need_l |-> ##[0:2] !lower_level_o) else $error("level not restored");
endmodule : idca_access_chk
bind idca_access idca_access_chk u_chk (.clk_i, .reset_n_i, .d_slot_i, .echo_slot_i,
    .echo_bit_i, .req_pending_i, .req_class2_i, .req_bit_i, .req_last_i, .d_bit_o,
    .bit_take_o, .frame_done_o, .frame_abort_o, .lower_level_o);

// ### verification/idca_nt_model.sv
// Purpose: Network end: slot strobes and echo of each received D bit
// Assumes: Sixteen clocks per D slot, echo well before the next slot
// Notes: flip_i corrupts one echo; echo bit inverts outside its hold window
module idca_nt_model (
    input wire logic clk_i, // Clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic d_bit_i, // D bit from the terminal
    input wire logic flip_i, // Corrupt the echo being captured
    output logic d_slot_o, // D slot strobe
    output logic echo_slot_o, // Echo slot strobe
    output logic echo_bit_o // Echo bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ph;
    logic e;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ph <= 4'h0;
            e <= 1'b1;
            d_slot_o <= 1'b0;
            echo_slot_o <= 1'b0;
            echo_bit_o <= 1'b0;
        end else begin
            ph <= ph + 4'h1;
            d_slot_o <= ph < 4'h4;
            echo_slot_o <= ph >= 4'h9 && ph <= 4'hc;
            if (ph == 4'h7)
                e <= d_bit_i ^ flip_i;
            echo_bit_o <= (ph >= 4'h8 && ph <= 4'hd) ? e : ~e;
        end
    end
endmodule : idca_nt_model

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the D-channel access block
// Assumes: Four-bit frames 0,1,1,0; model gives slot timing
// Notes: Echo ONE count kept here from the line, not from the block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, reset_n_i = 0, req_pending_i = 0, req_class2_i = 0;
    logic req_bit_i = 0, req_last_i = 0, flip = 0, es_q = 0;
    logic [3:0] pat = 4'h6;
    logic d_slot_i, echo_slot_i, echo_bit_i, d_bit_o, bit_take_o, frame_done_o;
    logic frame_abort_o, lower_level_o;
    int error_cnt = 0, n_checks = 0, cyc = 0, ones = 0, idx = 0;
    always #25 clk_i = ~clk_i;
    idca_access u_dut (.clk_i, .reset_n_i, .d_slot_i, .echo_slot_i, .echo_bit_i,
        .req_pending_i, .req_class2_i, .req_bit_i, .req_last_i, .d_bit_o, .bit_take_o,
        .frame_done_o, .frame_abort_o, .lower_level_o);
    idca_nt_model u_nt (.clk_i, .reset_n_i, .d_bit_i(d_bit_o), .flip_i(flip),
        .d_slot_o(d_slot_i), .echo_slot_o(echo_slot_i), .echo_bit_o(echo_bit_i));
    task check(input logic seen, input logic exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %b want %b", $time, seen, exp);
        end
    endtask : check
    task results;
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    // Layer 2 feeder and line-side echo ONE count
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results;
        end
        es_q <= echo_slot_i;
        if (echo_slot_i && !es_q) ones = echo_bit_i ? ones + 1 : 0;
        if (frame_done_o || frame_abort_o) begin
            ones = 0;
            idx = 0;
        end else if (bit_take_o) idx = idx + 1;
        req_bit_i <= pat[idx % 4];
        req_last_i <= (idx == 3);
    end
    // Sampled mid-cycle so the feeder's updates have landed
    task wt(input int k);
        do @(negedge clk_i);
        while (!(k == 0 ? bit_take_o : k == 1 ? frame_done_o : frame_abort_o));
    endtask : wt
    task drain(input int n);
        @(posedge clk_i) req_pending_i <= 0;
        while (ones < n) @(negedge clk_i);
        repeat (4) @(negedge clk_i);
    endtask : drain
    task t_clean(input logic c2);
        @(posedge clk_i) req_class2_i <= c2;
        req_pending_i <= 1;
        wt(1);
        repeat (2) @(negedge clk_i);
        check(lower_level_o, 1'b1);
        wt(0);
        check(ones >= (c2 ? 11 : 9), 1'b1);
        wt(1);
        drain(c2 ? 11 : 9);
        check(lower_level_o, 1'b0);
    endtask : t_clean
    // n = 1 corrupts a sent ZERO, n = 2 a sent ONE
    task t_abort(input logic c2, input int n);
        @(posedge clk_i) req_class2_i <= c2;
        req_pending_i <= 1;
        repeat (n) wt(0);
        @(posedge clk_i) flip <= 1;
        repeat (8) @(posedge clk_i);
        flip <= 0;
        wt(2);
        repeat (16) @(negedge clk_i);
        check(d_bit_o, 1'b1);
        wt(0);
        check(ones >= (c2 ? 10 : 8), 1'b1);
        wt(1);
        drain(12);
    endtask : t_abort
    initial begin
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1;
        t_clean(1'b0);
        t_clean(1'b1);
        t_abort(1'b0, 1);
        t_abort(1'b1, 2);
        t_abort(1'b1, 1);
        t_abort(1'b0, 2);
        results;
    end
endmodule : tb_top
